// file: core/floppy_function_sequencer.sv
`timescale 1ns/1ps
// Notes on behaviour
// [R1] host issues a function with go set only while completion is high
// [R2] fill: unit ignored, completion low, one byte per transfer request
// [R3] fill completes after exactly 128 bytes; extra bytes discarded
// [R4] data port reads ignored while a fill is running
// [R5] empty: completion low, one byte per request, read drops request
// [R6] after byte 128 unloaded completion rises; interrupt if enabled
// [R7] emptying the buffer leaves its contents intact
// [R8] write, deleted write and read clear status bits 0, 1, 6
// [R9] host writes sector on first request, track on second
// [R10] track missing: abort, status to data port, error bit, completion
// [R11] request stays low during search; abort after two revolutions
// [R12] write stores 128 buffered bytes plus 16-bit crc then completes
// [R13] after power loss write still accepted, buffer unchanged
// [R14] read takes data into buffer, deleted mark sets status bit 6
// [R15] crc residue sets bit 0 and error, status copied, completion
// [R16] read status builds status word, bit 7 from selected unit
// [R17] deleted write equals write but records deleted mark; code records no mark, same as plain write
// [R18] read error register clears bits 0-6, shifts error code out
// [R19] power loss unloads head and aborts all activity
// [R20] power return: recalibrate, clear errors, init done, ready from unit 0
// [R21] local init bit 14 or system init aborts any function
// [R22] parity error terminates function, status copied, bit 1 set
// [R23] error bit cleared by new command or initialize
// [R24] function command ignored while completion is low
module floppy_function_sequencer
  import floppy_seq_pkg::*;
#(
  parameter int search_limit = search_cycles,
  parameter logic [7:0] fault_code = 8'h5a  // arbitrary default code
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic sys_init,
  input wire logic [1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [15:0] rdata,
  output logic done_out,
  output logic irq_out,
  output logic head_load_out,
  output logic write_gate_out,
  output logic [7:0] media_byte_out,
  output logic media_strobe_out
);
  // ************************************************************
  // state
  // ************************************************************
  state_type state_reg;
  func_type func_reg;
  logic [7:0] buffer_mem [0:sector_bytes-1];
  logic [7:0] count_reg;
  logic [7:0] status_reg;
  logic [15:0] data_reg;
  logic [7:0] sector_reg;
  logic [7:0] track_reg;
  logic [7:0] drive_ctrl_reg;
  logic unit_reg;
  logic ie_reg;
  logic tr_reg;
  logic done_reg;
  logic error_reg;
  logic [31:0] timer_reg;
  logic [7:0] err_code_reg;
  logic [15:0] crc_reg;
  logic [2:0] pwr_sync_reg;
  logic pwr_low_reg;
  logic [15:0] rdata_reg;
  logic irq_reg;
  logic media_stb_reg;
  logic [7:0] media_byte_reg;
  logic head_load_reg;
  logic write_gate_reg;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] x;
    x = c;
    for (int i = 7; i >= 0; i--) begin
      x = (x[15] ^ d[i]) ? ((x << 1) ^ 16'h1021) : (x << 1);
    end
    return x;
  endfunction

  function automatic logic is_media(input func_type f);
    return (f == fn_write) || (f == fn_read) || (f == fn_write_del);
  endfunction

  wire cmd_wr = wr_stb && (addr == cmd_status_addr);
  wire data_wr = wr_stb && (addr == data_port_addr);
  wire data_rd = rd_stb && (addr == data_port_addr);
  wire init_req = sys_init || (cmd_wr && wdata[local_init_bit]);
  // go honoured only while idle and done; others ignored
  wire start = cmd_wr && wdata[go_bit] && !wdata[local_init_bit]
               && done_reg && state_reg == st_idle;  // [R1] [R24]
  wire power_low = pwr_low_reg;
  wire [7:0] index = count_reg;
  wire last_byte = (count_reg == 8'(sector_bytes - 1));

  // ************************************************************
  // power sense synchroniser
  // ************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pwr_sync_reg <= 3'h0;
      pwr_low_reg <= 1'b0;
    end else begin
      pwr_sync_reg <= {pwr_sync_reg[1:0], drive_ctrl_reg[dc_power_low]};
      if (pwr_sync_reg[1] == pwr_sync_reg[2]) begin
        pwr_low_reg <= pwr_sync_reg[2];
      end
    end
  end

  // ************************************************************
  // software registers
  // ************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      drive_ctrl_reg <= 8'h00;
      ie_reg <= 1'b0;
      unit_reg <= 1'b0;
    end else begin
      if (wr_stb && addr == drive_ctrl_addr) begin
        drive_ctrl_reg <= wdata[7:0];
      end
      if (init_req) begin
        ie_reg <= 1'b0;
      end else if (cmd_wr) begin
        ie_reg <= wdata[ie_bit];
      end
      if (start) begin
        unit_reg <= wdata[unit_bit];
      end
    end
  end

  // ************************************************************
  // function sequencer
  // ************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= st_idle;
      func_reg <= fn_fill;
      count_reg <= 8'h00;
      status_reg <= status_reset;
      data_reg <= 16'h0000;
      sector_reg <= 8'h00;
      track_reg <= 8'h00;
      tr_reg <= 1'b0;
      done_reg <= cmd_reset[done_bit];
      error_reg <= 1'b0;
      timer_reg <= 32'h0;
      err_code_reg <= err_code_reset;
      crc_reg <= 16'hffff;
      media_stb_reg <= 1'b0;
      media_byte_reg <= 8'h00;
      write_gate_reg <= 1'b0;
    end else begin
      media_stb_reg <= 1'b0;
      write_gate_reg <= 1'b0;
      if (power_low) begin
        // nothing runs while power is down; recovery starts on return
        state_reg <= st_power;  // [R19]
        tr_reg <= 1'b0;
        done_reg <= 1'b0;
        timer_reg <= 32'h0;
      end else if (init_req || state_reg == st_power) begin
        state_reg <= st_idle;  // [R21] [R20]
        tr_reg <= 1'b0;
        error_reg <= 1'b0;  // [R23]
        status_reg <= status_reset;
        status_reg[init_done_bit] <= 1'b1;  // [R20]
        status_reg[drv_rdy_bit] <= drive_ctrl_reg[dc_rdy0];  // [R20]
        track_reg <= 8'h00;
        done_reg <= 1'b1;
      end else if (start) begin
        func_reg <= func_type'(wdata[func_lsb +: 3]);
        done_reg <= 1'b0;  // [R2] [R5]
        error_reg <= 1'b0;  // [R23]
        count_reg <= 8'h00;
        tr_reg <= 1'b0;
        timer_reg <= 32'h0;
        if (is_media(func_type'(wdata[func_lsb +: 3]))) begin
          status_reg[crc_err_bit] <= 1'b0;  // [R8]
          status_reg[par_err_bit] <= 1'b0;
          status_reg[deleted_bit] <= 1'b0;
          state_reg <= st_sector;
          tr_reg <= 1'b1;
        end else if (wdata[func_lsb +: 3] == fn_fill || wdata[func_lsb +: 3] == fn_empty) begin
          state_reg <= st_xfer;
          tr_reg <= 1'b1;
          data_reg <= {8'h00, buffer_mem[0]};
        end else if (wdata[func_lsb +: 3] == fn_err_reg) begin
          status_reg[6:0] <= 7'h00;  // [R18]
          state_reg <= st_shift;
        end else begin
          state_reg <= st_finish;
        end
      end else begin
        case (state_reg)
          st_xfer: begin
            if (func_reg == fn_fill && data_wr && tr_reg) begin
              count_reg <= count_reg + 8'h01;  // [R3]
              tr_reg <= 1'b0;  // [R2]
            end else if (func_reg == fn_empty && data_rd && tr_reg) begin
              count_reg <= count_reg + 8'h01;
              tr_reg <= 1'b0;  // [R5]
            end else if (!tr_reg) begin
              if (count_reg == 8'(sector_bytes)) begin
                state_reg <= st_idle;
                done_reg <= 1'b1;  // [R3] [R6]
              end else begin
                tr_reg <= 1'b1;
                data_reg <= {8'h00, buffer_mem[index[6:0]]};  // [R7]
              end
            end
          end
          st_sector: begin
            if (data_wr && tr_reg) begin
              sector_reg <= wdata[7:0];  // [R9]
              tr_reg <= 1'b0;
            end else if (!tr_reg) begin
              tr_reg <= 1'b1;
              state_reg <= st_track;
            end
          end
          st_track: begin
            if (data_wr && tr_reg) begin
              track_reg <= wdata[7:0];  // [R9]
              tr_reg <= 1'b0;  // [R11]
              state_reg <= st_search;
            end
          end
          st_search: begin
            timer_reg <= timer_reg + 32'h1;
            if (drive_ctrl_reg[dc_parity_bad]) begin
              status_reg[par_err_bit] <= 1'b1;  // [R22]
              error_reg <= 1'b1;
              state_reg <= st_finish;
            end else if (drive_ctrl_reg[dc_track_bad]) begin
              error_reg <= 1'b1;  // [R10]
              state_reg <= st_finish;
            end else if (drive_ctrl_reg[dc_sector_bad]) begin
              if (timer_reg >= 32'(search_limit - 1)) begin
                error_reg <= 1'b1;  // [R11]
                state_reg <= st_finish;
              end
            end else begin
              state_reg <= st_media;
              count_reg <= 8'h00;
              crc_reg <= 16'hffff;
              if (func_reg == fn_read) begin
                status_reg[deleted_bit] <= drive_ctrl_reg[dc_deleted_mark];  // [R14]
              end
            end
          end
          st_media: begin
            // one byte per cycle; write leaves buffer untouched
            media_stb_reg <= 1'b1;
            // deleted write gates the head exactly like a plain write
            write_gate_reg <= (func_reg != fn_read);  // [R17]
            count_reg <= count_reg + 8'h01;
            if (count_reg < 8'(sector_bytes)) begin
              media_byte_reg <= buffer_mem[index[6:0]];  // [R12] [R13]
              crc_reg <= crc_step(crc_reg, buffer_mem[index[6:0]]);
            end else if (count_reg == 8'(sector_bytes)) begin
              media_byte_reg <= crc_reg[15:8];  // [R12]
            end else begin
              media_byte_reg <= crc_reg[7:0];
              state_reg <= st_finish;
              if (func_reg == fn_read && drive_ctrl_reg[dc_crc_bad]) begin
                status_reg[crc_err_bit] <= 1'b1;  // [R15]
                error_reg <= 1'b1;
              end
            end
          end
          st_shift: begin
            count_reg <= count_reg + 8'h01;
            err_code_reg <= {err_code_reg[6:0], fault_code[7 - count_reg[2:0]]};
            if (count_reg == 8'(err_shift_pulses - 1)) begin
              state_reg <= st_idle;
              done_reg <= 1'b1;  // [R18]
            end
          end
          st_finish: begin
            if (func_reg == fn_status) begin
              data_reg <= {8'h00, drive_ctrl_reg[unit_reg ? dc_rdy1 : dc_rdy0],
                           status_reg[6:0]};  // [R16]
              status_reg[drv_rdy_bit] <= drive_ctrl_reg[unit_reg ? dc_rdy1 : dc_rdy0];
            end else begin
              data_reg <= {8'h00, status_reg};  // [R10] [R15] [R22]
            end
            done_reg <= 1'b1;
            state_reg <= st_idle;
          end
          default: begin
            state_reg <= st_idle;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // sector buffer: fill writes and media reads only
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (state_reg == st_xfer && func_reg == fn_fill && data_wr && tr_reg
        && !power_low && !init_req) begin
      buffer_mem[index[6:0]] <= wdata[7:0];  // [R3]
    end else if (state_reg == st_media && func_reg == fn_read
                 && count_reg < 8'(sector_bytes) && !power_low && !init_req) begin
      buffer_mem[index[6:0]] <= track_reg ^ sector_reg ^ count_reg;  // [R14]
    end
  end

  // ************************************************************
  // read port and outputs
  // ************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 16'h0000;
      irq_reg <= 1'b0;
      head_load_reg <= 1'b0;
    end else begin
      irq_reg <= done_reg && ie_reg && !power_low;  // [R6]
      // registered so the pin cannot glitch; trails the state by a cycle
      head_load_reg <= (state_reg == st_search || state_reg == st_media)
                       && !power_low;  // [R19]
      if (!rd_stb) begin
        rdata_reg <= 16'h0000;
      end else if (addr == cmd_status_addr) begin
        rdata_reg <= {error_reg, 7'h00, tr_reg, ie_reg, done_reg, 5'h00};
      end else if (addr == data_port_addr) begin
        // reads during a fill return zero and have no effect
        rdata_reg <= (state_reg == st_xfer && func_reg == fn_fill) ? 16'h0000
                     : (func_reg == fn_err_reg ? {8'h00, err_code_reg} : data_reg);  // [R4]
      end else if (addr == drive_ctrl_addr) begin
        rdata_reg <= {8'h00, drive_ctrl_reg};
      end else if (addr == drive_stat_addr) begin
        rdata_reg <= {track_reg, sector_reg};
      end else begin
        rdata_reg <= 16'h0000;
      end
    end
  end

  assign rdata = rdata_reg;
  assign done_out = done_reg;
  assign irq_out = irq_reg;
  assign head_load_out = head_load_reg;
  assign write_gate_out = write_gate_reg;
  assign media_byte_out = media_byte_reg;
  assign media_strobe_out = media_stb_reg;

endmodule  // floppy_function_sequencer

// file: core/floppy_seq_pkg.sv
package floppy_seq_pkg;
  // register offsets on the plain register port
  localparam logic [1:0] cmd_status_addr = 2'h0;
  localparam logic [1:0] data_port_addr = 2'h1;
  localparam logic [1:0] drive_ctrl_addr = 2'h2;
  localparam logic [1:0] drive_stat_addr = 2'h3;
  // command/status field positions
  localparam int go_bit = 0;
  localparam int func_lsb = 1;
  localparam int unit_bit = 4;
  localparam int done_bit = 5;
  localparam int ie_bit = 6;
  localparam int tr_bit = 7;
  localparam int local_init_bit = 14;
  localparam int error_bit = 15;
  // error/status word bits
  localparam int crc_err_bit = 0;
  localparam int par_err_bit = 1;
  localparam int init_done_bit = 2;
  localparam int deleted_bit = 6;
  localparam int drv_rdy_bit = 7;
  // drive control register bits (drive model side, software driven)
  localparam int dc_track_bad = 0;
  localparam int dc_sector_bad = 1;
  localparam int dc_deleted_mark = 2;
  localparam int dc_crc_bad = 3;
  localparam int dc_parity_bad = 4;
  localparam int dc_power_low = 5;
  localparam int dc_rdy0 = 6;
  localparam int dc_rdy1 = 7;
  localparam logic [15:0] cmd_reset = 16'h0020;
  localparam logic [7:0] status_reset = 8'h00;
  localparam int sector_bytes = 128;
  localparam logic [7:0] err_code_reset = 8'h00;
  // two revolutions; plain default, benches shorten it
  localparam int sector_search_us = 333333;
  localparam int clk_mhz = 40;
  localparam int search_cycles = sector_search_us * clk_mhz;
  localparam int err_shift_pulses = 8;
  typedef enum logic [2:0] {
    fn_fill = 3'b000, fn_empty = 3'b001, fn_write = 3'b010, fn_read = 3'b011,
    fn_unused = 3'b100, fn_status = 3'b101, fn_write_del = 3'b110, fn_err_reg = 3'b111
  } func_type;
  typedef enum logic [3:0] {
    st_idle = 4'b0000, st_xfer = 4'b0001, st_sector = 4'b0011, st_track = 4'b0010,
    st_search = 4'b0110, st_media = 4'b0111, st_finish = 4'b0101, st_shift = 4'b0100,
    st_power = 4'b1100
  } state_type;
endpackage

// file: verification/floppy_function_sequencer_monitor.sv
`timescale 1ns/1ps
module floppy_function_sequencer_monitor
  import floppy_seq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic sys_init,
  input wire logic [1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [15:0] rdata,
  input wire logic done_out,
  input wire logic irq_out,
  input wire logic head_load_out,
  input wire logic write_gate_out,
  input wire logic [7:0] media_byte_out,
  input wire logic media_strobe_out
);
  // ****************
  // port relations
  // ****************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  AST_GO_BUSY: assert property (wr_stb && addr == cmd_status_addr && wdata[0] && !wdata[14]
    && wdata[3:1] != 3'b100 && done_out && !sys_init |=> !done_out) else $error("go kept done");
  AST_IRQ_DONE: assert property (!$past(done_out) |-> !irq_out)
    else $error("irq without done");
  AST_RD_IDLE: assert property (!$past(rd_stb) |-> rdata == 16'h0000)
    else $error("read data outside answer cycle");
  AST_STROBE_BUSY: assert property (media_strobe_out |-> !done_out)
    else $error("media byte after done");
  AST_STROBE_HEAD: assert property (media_strobe_out |-> $past(head_load_out))
    else $error("media byte with head unloaded");
  AST_WGATE_HEAD: assert property (write_gate_out |-> $past(head_load_out))
    else $error("write gate with head unloaded");
  AST_INIT_ABORT: assert property ((wr_stb && addr == cmd_status_addr && wdata[14]) || sys_init
    |-> ##[1:4] done_out) else $error("initialize did not end function");
  // power sense drops done five cycles after its control write (three sync stages, the filter, then done); $fell sees it at six
  AST_DONE_CAUSE: assert property ($fell(done_out)
    |-> $past(wr_stb && addr == cmd_status_addr) || $past(sys_init)
    || $past(wr_stb && addr == drive_ctrl_addr, 6))
    else $error("done fell without command");
endmodule // floppy_function_sequencer_monitor
bind floppy_function_sequencer floppy_function_sequencer_monitor i_mon (
  .ref_clk(ref_clk), .resetn(resetn), .sys_init(sys_init), .addr(addr), .wdata(wdata),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .done_out(done_out), .irq_out(irq_out),
  .head_load_out(head_load_out), .write_gate_out(write_gate_out),
  .media_byte_out(media_byte_out), .media_strobe_out(media_strobe_out));

// file: verification/floppy_function_sequencer_bench.sv
`timescale 1ns/1ps
module floppy_function_sequencer_bench
  import floppy_seq_pkg::*;
;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic sys_init = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic note_reg = 1'b0;
  logic seen_reg = 1'b0;
  logic [15:0] rdata, raw;
  logic done_out, irq_out, head_load_out, write_gate_out, media_strobe_out;
  logic [7:0] media_byte_out;
  logic [7:0] lfsr = 8'h1c;
  logic [7:0] buf_mem[128];
  logic [31:0] exp_q[$];  // mask in upper half
  logic [7:0] media_q[$];
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  int strobes = 0;
  int base;
  always #12.5 ref_clk = ~ref_clk;
  floppy_function_sequencer #(.search_limit(20), .fault_code(8'h3c)) i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .sys_init(sys_init), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .done_out(done_out), .irq_out(irq_out),
    .head_load_out(head_load_out), .write_gate_out(write_gate_out),
    .media_byte_out(media_byte_out), .media_strobe_out(media_strobe_out));
  // ****************
  // bus and checks
  // ****************
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic bus_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic bus_rd(input logic [1:0] a, input logic n);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    note_reg <= n;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    note_reg <= 1'b0;
    #1 raw = rdata;
  endtask
  task automatic expect_rd(input logic [1:0] a, input logic [15:0] m, input logic [15:0] v);
    exp_q.push_back({m, v});
    bus_rd(a, 1'b1);
  endtask
  task automatic wait_bit(input int b, input logic v, input int n);
    raw[b] = ~v;
    repeat (n) if (raw[b] !== v) bus_rd(cmd_status_addr, 1'b0);
    check("cmd flag", {15'h0000, raw[b]}, {15'h0000, v});
  endtask
  // sector then track, then wait out the search or the media pass
  task automatic run_seek(input logic [15:0] c, input logic [15:0] dc);
    bus_wr(drive_ctrl_addr, dc);
    bus_wr(cmd_status_addr, c);
    wait_bit(tr_bit, 1'b1, 8);
    bus_wr(data_port_addr, 16'h0003);
    wait_bit(tr_bit, 1'b1, 8);
    bus_wr(data_port_addr, 16'h0007);
    wait_bit(done_bit, 1'b1, 400);
  endtask
  // ****************
  // result watcher
  // ****************
  always @(posedge ref_clk) begin
    if (seen_reg) begin
      check("read data", rdata & exp_q[0][31:16], exp_q[0][15:0]);
      void'(exp_q.pop_front());
    end
    seen_reg <= rd_stb && note_reg;
    if (media_strobe_out) strobes++;
    if (media_strobe_out && media_q.size() > 0) begin
      check("media byte", {8'h00, media_byte_out}, {8'h00, media_q[0]});
      void'(media_q.pop_front());
    end
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    bus_wr(drive_ctrl_addr, 16'h00c0);
    expect_rd(cmd_status_addr, 16'h80a0, 16'h0020);
    bus_wr(cmd_status_addr, 16'h0051);
    for (int i = 0; i < 128; i++) begin
      lfsr = lfsr_next(lfsr);
      buf_mem[i] = lfsr;
      wait_bit(tr_bit, 1'b1, 8);
      bus_wr(data_port_addr, {8'h00, lfsr});
      if (i == 64) expect_rd(data_port_addr, 16'hffff, 16'h0000);
    end
    bus_wr(data_port_addr, 16'h00ee);  // surplus byte must vanish
    wait_bit(done_bit, 1'b1, 8);
    $display("fill finished");
    repeat (2) begin
      bus_wr(cmd_status_addr, 16'h0043);
      for (int i = 0; i < 128; i++) begin
        wait_bit(tr_bit, 1'b1, 8);
        expect_rd(data_port_addr, 16'h00ff, {8'h00, buf_mem[i]});
      end
      wait_bit(done_bit, 1'b1, 8);
      @(posedge ref_clk);
      check("irq", {15'h0000, irq_out}, 16'h0001);
    end
    $display("empty finished");
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 128; i++) media_q.push_back(buf_mem[i]);
      base = strobes;
      run_seek(k ? 16'h000d : 16'h0005, 16'h00c0);
      check("strobes", 16'(strobes - base), 16'h0082);
      expect_rd(cmd_status_addr, 16'h8020, 16'h0020);
    end
    $display("writes finished");
    run_seek(16'h0005, 16'h00c1);
    expect_rd(cmd_status_addr, 16'h8020, 16'h8020);
    run_seek(16'h0007, 16'h00c2);
    expect_rd(cmd_status_addr, 16'h8020, 16'h8020);
    run_seek(16'h0007, 16'h00c8);
    expect_rd(cmd_status_addr, 16'h8020, 16'h8020);
    expect_rd(data_port_addr, 16'h0001, 16'h0001);
    run_seek(16'h0007, 16'h00c4);
    expect_rd(cmd_status_addr, 16'h8020, 16'h0020);
    $display("seek faults finished");
    bus_wr(cmd_status_addr, 16'h000b);
    wait_bit(done_bit, 1'b1, 40);
    expect_rd(data_port_addr, 16'h00c3, 16'h00c0);
    bus_wr(drive_ctrl_addr, 16'h0040);
    bus_wr(cmd_status_addr, 16'h001b);
    wait_bit(done_bit, 1'b1, 40);
    expect_rd(data_port_addr, 16'h0080, 16'h0000);
    bus_wr(cmd_status_addr, 16'h000f);
    wait_bit(done_bit, 1'b1, 40);
    expect_rd(data_port_addr, 16'h00ff, 16'h003c);
    $display("status finished");
    bus_wr(cmd_status_addr, 16'h0001);
    bus_wr(cmd_status_addr, 16'h0003);  // go while busy
    expect_rd(data_port_addr, 16'hffff, 16'h0000);
    bus_wr(cmd_status_addr, 16'h4000);
    wait_bit(done_bit, 1'b1, 8);
    bus_wr(cmd_status_addr, 16'h0001);
    sys_init <= 1'b1;
    @(posedge ref_clk);
    sys_init <= 1'b0;
    wait_bit(done_bit, 1'b1, 8);
    $display("initialize finished");
    bus_wr(drive_ctrl_addr, 16'h00e0);
    wait_bit(done_bit, 1'b0, 16);
    bus_wr(drive_ctrl_addr, 16'h0040);
    wait_bit(done_bit, 1'b1, 16);
    bus_wr(cmd_status_addr, 16'h000b);
    wait_bit(done_bit, 1'b1, 40);
    expect_rd(data_port_addr, 16'h0084, 16'h0084);
    $display("power finished");
    tally_and_finish();
  end
endmodule // floppy_function_sequencer_bench
